// *** genset_pkg.sv ***
// Summary of operation
// - Load mode value 8 selects the smallest generator count able to carry the load.
// - At most five generators are considered, six with the extended variant bit.
// - Search singles smallest first, then pairs, then triples and larger groups, first carrying group wins.
// - Only the start threshold still applies, as the pick limit; combination changes wait the start or stop delay.
// - Minimum-running zero allows all units off; above zero keeps one running.
// - Equal rated groups are used in rotation when rotation is enabled.
// - Start when load percentage exceeds start threshold or spare is below reserve.
// - Stop only when load without lowest unit is low and spare exceeds reserve.
// - Level 0 disables reserve; levels 1 to 3 pick a threshold pair.
// - Local reserve parameter changes are sent to peers; peer changes are applied.
// - Compute rated, rated without lowest, active, spare and spare without lowest.
// - Start when spare stays below the low threshold for the start delay.
// - Stop when spare without lowest stays above high threshold for stop delay.
// - A level is valid only with nonzero thresholds and low below high.
// - Integrated variant takes hysteresis from load thresholds, high thresholds unused.
// - An active level-select input forces the level and shares it with peers.
// - With several level inputs active, the highest level input wins.
// - Four indicator outputs show none, first, second or third level selected.
// - Ready stays low while loading and rises once paralleled with reserve covered.
// - Reserve-satisfied status is readable at register index 95.
package genset_pkg;
  localparam int NGEN = 6;
  localparam int PW   = 16;
  localparam int SW   = 20;
  localparam int TW   = 16;
  localparam int AW   = 12;
  localparam logic [AW-1:0] CTRL_OFF  = 12'h000;
  localparam logic [AW-1:0] LEVEL_OFF = 12'h004;
  localparam logic [AW-1:0] THR_OFF   = 12'h008;
  localparam logic [AW-1:0] PCT_OFF   = 12'h014;
  localparam logic [AW-1:0] DLY_OFF   = 12'h018;
  localparam logic [AW-1:0] RATED_OFF = 12'h020;
  localparam logic [AW-1:0] SPARE_OFF = 12'h040;
  localparam logic [AW-1:0] SPWO_OFF  = 12'h044;
  localparam logic [AW-1:0] FLAG_OFF  = 12'h048;
  localparam int RES_OK_IDX = 95;
  localparam logic [AW-1:0] RES_OK_OFF = AW'(4 * RES_OK_IDX);
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PCT_RST  = 32'h0000_3C50;
  localparam logic [31:0] DLY_RST  = 32'h0010_0010;
  localparam logic [3:0]  MODE_MIN_COUNT = 4'h8;
  localparam int CTRL_EXT6_BIT  = 8;
  localparam int CTRL_INTEG_BIT = 9;
  localparam int CTRL_ROT_BIT   = 10;
  localparam logic [1:0] LVL_OFF_C = 2'h0;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h2;
  localparam logic [1:0] LVL_3 = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] PCT_SCALE = 32'h0000_0064;

  function automatic logic [SW-1:0] mask_sum(input logic [NGEN*PW-1:0] v, input logic [NGEN-1:0] m);
    logic [SW-1:0] s;
    s = '0;
    for (int i = 0; i < NGEN; i++) begin
      if (m[i]) begin
        s = s + SW'(v[i*PW +: PW]);
      end
    end
    return s;
  endfunction

  function automatic logic over_pct(input logic [SW-1:0] kw, input logic [SW-1:0] cap, input logic [7:0] pct);
    return (32'(kw) * PCT_SCALE) > (32'(cap) * 32'(pct));
  endfunction
endpackage

// *** min_count_pick.sv ***
`timescale 1ns/1ps
module min_count_pick
  import genset_pkg::*;
(
  input  wire logic [NGEN*PW-1:0] rated,
  input  wire logic [NGEN-1:0]    incl,
  input  wire logic [SW-1:0]      load_kw,
  input  wire logic [7:0]         start_pct,
  input  wire logic               allow6,
  input  wire logic               keep_one,
  input  wire logic               rot,
  output logic      [NGEN-1:0]    pick
);
  logic [NGEN-1:0] cand;
  logic [NGEN-1:0] best;
  logic [SW-1:0]   sum;
  logic [SW-1:0]   bsum;
  logic [3:0]      cnt;
  logic [3:0]      bcnt;
  logic            found;
  logic            better;

  // Exhaustive scan: fewest units first, then smallest rated sum
  always_comb begin
    best   = '0;
    bsum   = '0;
    bcnt   = '0;
    found  = 1'b0;
    cand   = '0;
    sum    = '0;
    cnt    = '0;
    better = 1'b0;
    for (int m = 1; m < (1 << NGEN); m++) begin
      cand = NGEN'(m);
      sum  = mask_sum(rated, cand);
      cnt  = 4'($countones(cand));
      better = !found || cnt < bcnt || (cnt == bcnt && (sum < bsum || (sum == bsum && rot)));
      if ((allow6 || !cand[NGEN-1]) && (cand & ~incl) == '0 && !over_pct(load_kw, sum, start_pct) && better) begin
        best  = cand;
        bsum  = sum;
        bcnt  = cnt;
        found = 1'b1;
      end
    end
    if (load_kw == '0 && !keep_one) begin
      pick = '0;
    end else if (found) begin
      pick = best;
    end else begin
      pick = incl & {allow6, {(NGEN-1){1'b1}}};
    end
  end
endmodule

// *** genset_reserve_sel.sv ***
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module genset_reserve_sel
  import genset_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [AW-1:0]      awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [AW-1:0]      araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic [NGEN-1:0]    gen_running,
  input  wire logic [NGEN-1:0]    gen_included,
  input  wire logic [NGEN*PW-1:0] gen_active,
  input  wire logic [2:0]         lowest_idx,
  input  wire logic [SW-1:0]      load_kw,
  input  wire logic               units_paralleled,
  input  wire logic               units_loading,
  input  wire logic               input_reserve_off,
  input  wire logic               input_reserve_lvl1,
  input  wire logic               input_reserve_lvl2,
  input  wire logic               input_reserve_lvl3,
  input  wire logic               peer_wr,
  input  wire logic [AW-1:0]      peer_addr,
  input  wire logic [31:0]        peer_data,
  output logic                    share_valid,
  output logic [AW-1:0]           share_addr,
  output logic [31:0]             share_data,
  output logic                    out_reserve_none,
  output logic                    out_reserve_lvl1,
  output logic                    out_reserve_lvl2,
  output logic                    out_reserve_lvl3,
  output logic                    out_reserve_ready,
  output logic                    start_req,
  output logic                    stop_req,
  output logic [NGEN-1:0]         combo_mask
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0]   ctrl_r, pct_r, dly_r;
  logic [31:0]   thr_r [3];
  logic [31:0]   rated_r [NGEN];
  logic [1:0]    lvl_r, lvl_nxt;
  logic          aw_hold_r, w_hold_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic [31:0]   rd_mux;
  logic          rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_hit(input logic [AW-1:0] a);
    return a == CTRL_OFF || a == LEVEL_OFF || a == PCT_OFF || a == DLY_OFF ||
           (a >= THR_OFF && a < PCT_OFF) || (a >= RATED_OFF && a < RATED_OFF + AW'(4 * NGEN));
  endfunction

  function automatic logic is_shared(input logic [AW-1:0] a);
    return a == LEVEL_OFF || (a >= THR_OFF && a < PCT_OFF);
  endfunction

  wire do_wr  = aw_hold_r && w_hold_r;
  wire wr_ok  = wr_hit(awaddr_r);
  wire ro_hit = awaddr_r == SPARE_OFF || awaddr_r == SPWO_OFF || awaddr_r == FLAG_OFF || awaddr_r == RES_OK_OFF;
  wire [1:0] thr_widx  = 2'((awaddr_r - THR_OFF) >> 2);
  wire [2:0] rat_widx  = 3'((awaddr_r - RATED_OFF) >> 2);
  wire [1:0] thr_pidx  = 2'((peer_addr - THR_OFF) >> 2);
  wire       wr_thr    = do_wr && awaddr_r >= THR_OFF && awaddr_r < PCT_OFF;
  wire       wr_rat    = do_wr && awaddr_r >= RATED_OFF && awaddr_r < RATED_OFF + AW'(4 * NGEN);
  wire       wr_lvl    = do_wr && awaddr_r == LEVEL_OFF;
  wire       peer_thr  = peer_wr && peer_addr >= THR_OFF && peer_addr < PCT_OFF;
  wire       peer_lvl  = peer_wr && peer_addr == LEVEL_OFF;
  wire [31:0] wr_val   = merge(wr_lvl ? {30'h0, lvl_r} : wr_thr ? thr_r[thr_widx] : 32'h0, wdata_r, wstrb_r);

  assign awready = !aw_hold_r && !bvalid;
  assign wready  = !w_hold_r && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (wr_ok || ro_hit) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      pct_r  <= PCT_RST;
      dly_r  <= DLY_RST;
      for (int i = 0; i < 3; i++) thr_r[i] <= '0;
      for (int i = 0; i < NGEN; i++) rated_r[i] <= '0;
    end else begin
      if (do_wr && awaddr_r == CTRL_OFF) ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
      if (do_wr && awaddr_r == PCT_OFF) pct_r <= merge(pct_r, wdata_r, wstrb_r);
      if (do_wr && awaddr_r == DLY_OFF) dly_r <= merge(dly_r, wdata_r, wstrb_r);
      if (wr_rat) rated_r[rat_widx] <= merge(rated_r[rat_widx], wdata_r, wstrb_r);
      if (wr_thr) begin
        thr_r[thr_widx] <= wr_val;
      end else if (peer_thr && thr_pidx != 2'h3) begin
        thr_r[thr_pidx] <= peer_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Level selection and sharing
  // ----------------------------------------------------------------
  wire       force_en  = input_reserve_off || input_reserve_lvl1 || input_reserve_lvl2 || input_reserve_lvl3;
  wire [1:0] force_val = input_reserve_lvl3 ? LVL_3 : input_reserve_lvl2 ? LVL_2 :
                         input_reserve_lvl1 ? LVL_1 : LVL_OFF_C;
  wire       force_chg = force_en && force_val != lvl_r;

  assign lvl_nxt = force_en ? force_val : wr_lvl ? wr_val[1:0] : peer_lvl ? peer_data[1:0] : lvl_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r       <= LVL_OFF_C;
      share_valid <= 1'b0;
      share_addr  <= '0;
      share_data  <= '0;
    end else begin
      lvl_r       <= lvl_nxt;
      // Peer writes are applied but never echoed, so a word cannot circle the network
      share_valid <= force_chg || (do_wr && is_shared(awaddr_r));
      if (force_chg || wr_lvl) begin
        share_addr <= LEVEL_OFF;
        share_data <= {30'h0, lvl_nxt};
      end else if (wr_thr) begin
        share_addr <= awaddr_r;
        share_data <= wr_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power sums and decisions
  // ----------------------------------------------------------------
  logic [NGEN*PW-1:0] rated_flat;
  always_comb begin
    rated_flat = '0;
    for (int i = 0; i < NGEN; i++) rated_flat[i*PW +: PW] = rated_r[i][PW-1:0];
  end

  wire [NGEN-1:0] low_mask  = gen_running & (NGEN'(1) << lowest_idx);
  wire [SW-1:0] rated_sum_running        = mask_sum(rated_flat, gen_running);
  wire [SW-1:0] rated_sum_without_lowest = mask_sum(rated_flat, gen_running & ~low_mask);
  wire [SW-1:0] active_sum_running       = mask_sum(gen_active, gen_running);
  wire [SW-1:0] spare_capacity = rated_sum_running > active_sum_running ?
                                 rated_sum_running - active_sum_running : '0;
  wire [SW-1:0] spare_capacity_without_lowest = rated_sum_without_lowest > active_sum_running ?
                                 rated_sum_without_lowest - active_sum_running : '0;

  wire        integ   = ctrl_r[CTRL_INTEG_BIT];
  wire        minmode = ctrl_r[3:0] == MODE_MIN_COUNT;
  wire [31:0] sel_thr = lvl_r == LVL_OFF_C ? 32'h0 : thr_r[lvl_r - 2'h1];
  wire [SW-1:0] thr_lo = SW'(sel_thr[PW-1:0]);
  wire [SW-1:0] thr_hi = SW'(sel_thr[31:PW]);
  wire        lvl_ok  = thr_lo != '0 && (integ || (thr_hi != '0 && thr_lo < thr_hi));
  wire        res_en  = lvl_r != LVL_OFF_C && lvl_ok;
  // Integrated variant folds the reserve into the load seen by the percentage checks
  wire [SW-1:0] act_eff = active_sum_running + ((res_en && integ) ? thr_lo : '0);
  wire        ld_start = over_pct(act_eff, rated_sum_running, pct_r[7:0]);
  wire        ld_stop  = !over_pct(act_eff, rated_sum_without_lowest, pct_r[15:8]) &&
                         32'(act_eff) * PCT_SCALE != 32'(rated_sum_without_lowest) * 32'(pct_r[15:8]);
  wire        rs_start = res_en && !integ && spare_capacity < thr_lo;
  wire        rs_stop  = !res_en || integ || spare_capacity_without_lowest > thr_hi;

  logic [NGEN-1:0] pick;
  logic            rot_r;
  min_count_pick u_pick (
    .rated     (rated_flat),
    .incl      (gen_included),
    .load_kw   (act_eff),
    .start_pct (pct_r[7:0]),
    .allow6    (ctrl_r[CTRL_EXT6_BIT]),
    .keep_one  (ctrl_r[7:4] != 4'h0),
    .rot       (rot_r && ctrl_r[CTRL_ROT_BIT]),
    .pick      (pick)
  );

  wire grow       = (pick & ~combo_mask) != '0;
  wire start_cond = minmode ? (pick != combo_mask && grow) : (ld_start || rs_start);
  wire stop_cond  = minmode ? (pick != combo_mask && !grow) : (ld_stop && rs_stop);

  // ----------------------------------------------------------------
  // Delay timers
  // ----------------------------------------------------------------
  // A zero delay acts as a one-cycle delay, so a single qualifying cycle already fires
  wire [TW-1:0] dly_up = dly_r[TW-1:0] == '0 ? TW'(1) : dly_r[TW-1:0];
  wire [TW-1:0] dly_dn = dly_r[31:TW] == '0 ? TW'(1) : dly_r[31:TW];
  logic [TW-1:0] up_cnt_r, dn_cnt_r;
  wire up_fire = start_cond && up_cnt_r == dly_up - TW'(1);
  wire dn_fire = stop_cond && dn_cnt_r == dly_dn - TW'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_cnt_r   <= '0;
      dn_cnt_r   <= '0;
      start_req  <= 1'b0;
      stop_req   <= 1'b0;
      combo_mask <= '0;
      rot_r      <= 1'b0;
    end else begin
      up_cnt_r  <= (!start_cond || up_fire) ? '0 : up_cnt_r + TW'(1);
      dn_cnt_r  <= (!stop_cond || dn_fire) ? '0 : dn_cnt_r + TW'(1);
      start_req <= up_fire;
      stop_req  <= dn_fire;
      if (minmode && (up_fire || dn_fire)) begin
        combo_mask <= pick;
        rot_r      <= !rot_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicators and readback
  // ----------------------------------------------------------------
  wire ready_nxt = res_en && units_paralleled && !units_loading && spare_capacity >= thr_lo;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reserve_none  <= 1'b1;
      out_reserve_lvl1  <= 1'b0;
      out_reserve_lvl2  <= 1'b0;
      out_reserve_lvl3  <= 1'b0;
      out_reserve_ready <= 1'b0;
    end else begin
      out_reserve_none  <= lvl_nxt == LVL_OFF_C;
      out_reserve_lvl1  <= lvl_nxt == LVL_1;
      out_reserve_lvl2  <= lvl_nxt == LVL_2;
      out_reserve_lvl3  <= lvl_nxt == LVL_3;
      out_reserve_ready <= ready_nxt;
    end
  end

  wire [1:0] thr_ridx = 2'((araddr - THR_OFF) >> 2);
  wire [2:0] rat_ridx = 3'((araddr - RATED_OFF) >> 2);
  always_comb begin
    rd_hit = 1'b1;
    if (araddr == CTRL_OFF) rd_mux = ctrl_r;
    else if (araddr == LEVEL_OFF) rd_mux = {30'h0, lvl_r};
    else if (araddr >= THR_OFF && araddr < PCT_OFF) rd_mux = thr_r[thr_ridx];
    else if (araddr == PCT_OFF) rd_mux = pct_r;
    else if (araddr == DLY_OFF) rd_mux = dly_r;
    else if (araddr >= RATED_OFF && araddr < RATED_OFF + AW'(4 * NGEN)) rd_mux = rated_r[rat_ridx];
    else if (araddr == SPARE_OFF) rd_mux = 32'(spare_capacity);
    else if (araddr == SPWO_OFF) rd_mux = 32'(spare_capacity_without_lowest);
    else if (araddr == FLAG_OFF) rd_mux = {18'h0, combo_mask, 2'h0, stop_cond, start_cond, out_reserve_ready, res_en, lvl_r};
    else if (araddr == RES_OK_OFF) rd_mux = {31'h0, out_reserve_ready};
    else begin
      rd_mux = 32'h0;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_force_level: assert property (force_en |=> lvl_r == $past(force_val)) else $error("level not forced");
  a_lvl3_wins: assert property (input_reserve_lvl3 |=> lvl_r == LVL_3 && out_reserve_lvl3) else $error("lvl3 lost");
  a_ind_onehot: assert property ($onehot({out_reserve_none, out_reserve_lvl1, out_reserve_lvl2, out_reserve_lvl3})
    && out_reserve_none == (lvl_r == LVL_OFF_C)) else $error("indicator wrong");
  a_ready_loading: assert property (units_loading |=> !out_reserve_ready) else $error("ready while loading");
  a_invalid_off: assert property (lvl_r != LVL_OFF_C && thr_lo == '0 |-> !res_en) else $error("invalid level used");
  a_timer_restart: assert property (!start_cond |=> up_cnt_r == '0) else $error("start timer kept");
  a_start_delay: assert property (start_req |-> $past(start_cond) && $past(up_cnt_r) == $past(dly_up) - TW'(1))
    else $error("start early");
  a_stop_both: assert property (stop_req && !$past(minmode) |-> $past(ld_stop) && $past(rs_stop))
    else $error("stop without both");
  a_share_force: assert property (force_chg |=> share_valid && share_data[1:0] == lvl_r) else $error("no share");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  a_combo_pick: assert property (minmode && (up_fire || dn_fire) |=> combo_mask == $past(pick)) else $error("combo");

  c_start: cover property (start_req);
  c_stop: cover property (stop_req);
  c_ready: cover property (out_reserve_ready);
  c_combo: cover property (minmode && up_fire);
  c_share: cover property (share_valid && share_addr == LEVEL_OFF);
endmodule

// *** peer_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Peer controller on the plant network
// ----------------------------------------
module peer_model
  import genset_pkg::*;
(
  input  wire logic          aclk,
  output logic               peer_wr,
  output logic [AW-1:0]      peer_addr,
  output logic [31:0]        peer_data,
  input  wire logic          share_valid,
  input  wire logic [AW-1:0] share_addr,
  input  wire logic [31:0]   share_data
);
  int          shares = 0;
  logic [31:0] last_share = 32'h0;
  initial begin
    peer_wr = 1'b0;
    peer_addr = '0;
    peer_data = '0;
  end
  // Peers count every shared word and keep a copy of the last one
  always @(posedge aclk) begin
    if (share_valid) begin
      shares <= shares + 1;
      last_share <= share_data;
    end
  end
  // Lines are inverted after the pulse so a stale word is never mistaken for a new one
  task automatic send(input logic [AW-1:0] a, input logic [31:0] d);
    peer_wr <= 1'b1;
    peer_addr <= a;
    peer_data <= d;
    @(posedge aclk);
    peer_wr <= 1'b0;
    peer_addr <= ~a;
    peer_data <= ~d;
  endtask
endmodule

// *** genset_reserve_and_min_count_selector_tb.sv ***
`timescale 1ns/1ps
module genset_reserve_and_min_count_selector_tb;
  import genset_pkg::*;
  logic aclk, aresetn = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0, share_addr, peer_addr;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, peer_data, share_data, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, peer_wr, share_valid, start_req, stop_req;
  logic out_reserve_none, out_reserve_lvl1, out_reserve_lvl2, out_reserve_lvl3, out_reserve_ready;
  logic [NGEN-1:0] gen_running = 6'h03, gen_included = 6'h03, combo_mask;
  logic [NGEN*PW-1:0] gen_active = '0;
  logic [2:0] lowest_idx = 3'h1;
  logic [SW-1:0] load_kw = '0;
  logic units_paralleled = 1'b1, units_loading = 1'b0;
  logic input_reserve_off = 1'b0, input_reserve_lvl1 = 1'b0, input_reserve_lvl2 = 1'b0, input_reserve_lvl3 = 1'b0;
  logic [1:0] l;
  int error_cnt = 0, total_checks = 0, cyc = 0, n;
  wire [31:0] ind_v = {28'h0, out_reserve_lvl3, out_reserve_lvl2, out_reserve_lvl1, out_reserve_none};

  genset_reserve_sel genset_reserve_sel_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .gen_running, .gen_included, .gen_active, .lowest_idx, .load_kw, .units_paralleled, .units_loading,
    .input_reserve_off, .input_reserve_lvl1, .input_reserve_lvl2, .input_reserve_lvl3, .peer_wr, .peer_addr,
    .peer_data, .share_valid, .share_addr, .share_data, .out_reserve_none, .out_reserve_lvl1, .out_reserve_lvl2,
    .out_reserve_lvl3, .out_reserve_ready, .start_req, .stop_req, .combo_mask);
  peer_model peer_model_inst (.aclk, .peer_wr, .peer_addr, .peer_data, .share_valid, .share_addr, .share_data);

  // ----------------------------------------
  // Clock, timeout and bench helpers
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] ind(input logic [1:0] v);
    return 32'h1 << v;
  endfunction
  function automatic logic [NGEN*PW-1:0] act(input int a0, input int a1);
    return {64'h0, 16'(a1), 16'(a0)};
  endfunction
  // Handshake flags sampled at the falling edge equal those seen at the next rising edge
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
    logic aw_t, w_t, b_t;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    logic a_t, r_t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      a_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse(input bit stp);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(stp ? stop_req : start_req) && n < 60);
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hEFF24D45));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(ind_v, ind(LVL_OFF_C));
    wr(DLY_OFF, 32'h0004_0004);
    wr(PCT_OFF, 32'h0000_3CFF);
    wr(RATED_OFF, 32'd500);
    wr(RATED_OFF + 12'h004, 32'd500);
    wr(THR_OFF, 32'h00C8_0064);
    wr(LEVEL_OFF, 32'h1);
    gen_active <= act(300, 300);
    repeat (3) @(posedge aclk);
    chk(out_reserve_ready, 1);
    rd(RES_OK_OFF);
    chk(d[0], 1);
    units_loading <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(out_reserve_ready, 0);
    units_loading <= 1'b0;
    // Spare 80 kW under a 100 kW floor, broken once to restart the timer
    gen_active <= act(460, 460);
    repeat (2) @(posedge aclk);
    gen_active <= act(300, 300);
    @(posedge aclk);
    gen_active <= act(460, 460);
    pulse(0);
    chk(n >= 4 && n <= 7, 1);
    gen_active <= act(100, 100);
    pulse(1);
    chk(n >= 4 && n <= 7, 1);
    gen_active <= act(300, 300);
    wr(PCT_OFF, 32'h0000_0AFF);
    gen_active <= act(100, 100);
    pulse(1);
    chk(n, 60);
    rd(FLAG_OFF);
    chk(d[2], 1);
    wr(THR_OFF, 32'h00C8_012C);
    rd(FLAG_OFF);
    chk(d[2], 0);
    input_reserve_lvl1 <= 1'b1;
    input_reserve_lvl3 <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(ind_v, ind(LVL_3));
    chk(peer_model_inst.last_share, 32'h3);
    chk(32'(share_addr), 32'(LEVEL_OFF));
    input_reserve_lvl1 <= 1'b0;
    input_reserve_lvl3 <= 1'b0;
    @(posedge aclk);
    peer_model_inst.send(LEVEL_OFF, 32'h2);
    repeat (3) @(posedge aclk);
    chk(ind_v, ind(LVL_2));
    rd(12'hFFC);
    chk(r, RESP_SLVERR);
    wr(12'hFFC, 32'h0);
    chk(r, RESP_SLVERR);
    // Only byte 0 is strobed, the upper bytes of the delay word must survive
    wstrb <= 4'h1;
    wr(DLY_OFF, 32'hFFFF_FF02);
    wstrb <= 4'hF;
    rd(DLY_OFF);
    chk(d, 32'h0004_0002);
    for (int i = 0; i < 8; i++) begin
      l = 2'($urandom);
      wr(LEVEL_OFF, {30'h0, l});
      repeat (2) @(posedge aclk);
      chk(ind_v, ind(l));
    end
    // Of the single units only the 700 kW unit carries 300 kW inside an 80 percent start limit
    wr(PCT_OFF, 32'h0000_3C50);
    wr(RATED_OFF, 32'd100);
    wr(RATED_OFF + 12'h004, 32'd300);
    wr(RATED_OFF + 12'h008, 32'd700);
    gen_included <= 6'h07;
    gen_running <= 6'h01;
    gen_active <= act(300, 0);
    wr(CTRL_OFF, 32'h0000_0018);
    repeat (30) @(posedge aclk);
    chk(combo_mask, 6'h04);
    // Twelve local changes were made; peer writes must not be echoed back
    chk(peer_model_inst.shares, 12);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(ind_v, ind(LVL_OFF_C));
    chk(combo_mask, 6'h00);
    complete_run();
  end
endmodule
